// *** core/mode_config_pkg.sv ***
// constants and types for the fieldbus mode configuration register bank
package mode_config_pkg;

    // ****************************************************************
    // clock and timing
    // ****************************************************************
    localparam int CLOCK_MHZ           = 100;
    localparam int IRQ_GAP_SHORT_US    = 1;
    localparam int IRQ_GAP_LONG_MS     = 1;
    localparam int TICK_SHORT_MS       = 1;
    localparam int TICK_LONG_MS        = 10;
    localparam int IRQ_GAP_SHORT_CYCLES = IRQ_GAP_SHORT_US * CLOCK_MHZ;
    localparam int IRQ_GAP_LONG_CYCLES  = IRQ_GAP_LONG_MS * CLOCK_MHZ * 1000;
    localparam int TICK_SHORT_CYCLES    = TICK_SHORT_MS * CLOCK_MHZ * 1000;
    localparam int TICK_LONG_CYCLES     = TICK_LONG_MS * CLOCK_MHZ * 1000;
    localparam int TIMER_WIDTH          = 20;

    // ****************************************************************
    // register map: printed index, byte address is four times it
    // ****************************************************************
    localparam int         ADDR_WIDTH     = 8;
    localparam int         IDX_MODE_LOW   = 'h06;
    localparam int         IDX_MODE_HIGH  = 'h07;
    localparam int         IDX_RUN_CTRL   = 'h10;
    localparam logic [7:0] ADDR_MODE_LOW  = 8'(IDX_MODE_LOW * 4);
    localparam logic [7:0] ADDR_MODE_HIGH = 8'(IDX_MODE_HIGH * 4);
    localparam logic [7:0] ADDR_RUN_CTRL  = 8'(IDX_RUN_CTRL * 4);

    // ****************************************************************
    // field layout and reset values
    // ****************************************************************
    localparam logic [15:0] MODE_CONFIG_RESET = 16'h0000;
    localparam logic [15:0] MODE_CONFIG_WMASK = 16'h3fff;
    localparam int          RUN_START_BIT     = 0;
    localparam int          RUN_STOP_BIT      = 1;

    typedef struct packed {
        logic [1:0] unused;
        logic       fail_safe_clear;
        logic       special_prm_buffer;
        logic       watchdog_test_sel;
        logic       user_tick_timebase;
        logic       irq_gap_timebase;
        logic       dp_protocol_enable;
        logic       freeze_supported;
        logic       sync_supported;
        logic       early_ready;
        logic       irq_polarity;
        logic       min_responder_delay_sel;
        logic       direct_broadcast_rx_en;
        logic       stop_bit_check_off;
        logic       start_bit_check_off;
    } mode_config_type;

endpackage

// *** core/period_timer.sv ***
// down counter that runs a loaded number of cycles and flags its last one
`timescale 1ns/1ps
`default_nettype none
module period_timer
    import mode_config_pkg::*;
#(
    parameter int WIDTH = TIMER_WIDTH
) (
    input  wire logic             i_clock,
    input  wire logic             i_rst_n,
    input  wire logic             i_start,
    input  wire logic [WIDTH-1:0] i_load,
    output logic                  o_busy,
    output logic                  o_last
);

    logic [WIDTH-1:0] count_q;
    logic             busy_q;

    // ****************************************************************
    // counter
    // ****************************************************************
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            count_q <= '0;
            busy_q  <= 1'b0;
        end else if (i_start) begin
            count_q <= i_load - WIDTH'(1);
            busy_q  <= 1'b1;
        end else if (busy_q) begin
            if (count_q == '0) begin
                busy_q <= 1'b0;
            end else begin
                count_q <= count_q - WIDTH'(1);
            end
        end
    end

    assign o_busy = busy_q;
    assign o_last = busy_q && (count_q == '0);

endmodule
`default_nettype wire

// *** core/fieldbus_mode_config.sv ***
// mode configuration register bank of a fieldbus slave controller
`timescale 1ns/1ps
`default_nettype none
module fieldbus_mode_config
    import mode_config_pkg::*;
#(
    parameter int GAP_LONG_CYCLES   = IRQ_GAP_LONG_CYCLES,
    parameter int TICK_SHORT_PERIOD = TICK_SHORT_CYCLES,
    parameter int TICK_LONG_PERIOD  = TICK_LONG_CYCLES
) (
    input  wire logic                  i_clock,
    input  wire logic                  i_rstn,
    input  wire logic                  i_wb_cyc,
    input  wire logic                  i_wb_stb,
    input  wire logic                  i_wb_we,
    input  wire logic [ADDR_WIDTH-1:0] i_wb_adr,
    input  wire logic [3:0]            i_wb_sel,
    input  wire logic [31:0]           i_wb_dat,
    output logic                       o_wb_ack,
    output logic [31:0]                o_wb_dat,
    input  wire logic                  i_prm_valid,
    input  wire logic [1:0]            i_prm_check_off,
    input  wire logic                  i_irq_request,
    input  wire logic                  i_eoi,
    output mode_config_type            o_config,
    output logic                       o_online,
    output logic                       o_dp_service_access_points,
    output logic                       o_irq_pin,
    output logic                       o_user_tick
);

    // ****************************************************************
    // helpers
    // ****************************************************************
    function automatic logic addr_hit(input logic [ADDR_WIDTH-1:0] adr,
                                      input logic [7:0]            target);
        addr_hit = (adr == target);
    endfunction

    function automatic logic [TIMER_WIDTH-1:0] pick_count(input logic sel,
                                                          input int   zero_val,
                                                          input int   one_val);
        pick_count = sel ? TIMER_WIDTH'(one_val) : TIMER_WIDTH'(zero_val);
    endfunction

    // ****************************************************************
    // reset release
    // ****************************************************************
    logic rst_meta_q;
    logic rst_n_q;

    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            rst_meta_q <= 1'b0;
            rst_n_q    <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n_q    <= rst_meta_q;
        end
    end

    // ****************************************************************
    // wishbone slave
    // ****************************************************************
    mode_config_type cfg_q;
    logic            online_q;
    logic            ack_q;
    logic            wait_q;
    logic            ack_d;
    logic            req;
    logic            commit;
    logic [31:0]     rdata;
    logic [31:0]     rdata_q;

    assign req    = i_wb_cyc && i_wb_stb && !ack_q;
    // early ready skips the wait state
    assign ack_d  = req && (cfg_q.early_ready || wait_q);
    assign commit = i_wb_cyc && i_wb_stb && i_wb_we && ack_q;

    always_ff @(posedge i_clock or negedge rst_n_q) begin
        if (!rst_n_q) begin
            ack_q  <= 1'b0;
            wait_q <= 1'b0;
        end else begin
            ack_q  <= ack_d;
            wait_q <= req && !ack_d;
        end
    end

    always_comb begin
        rdata = 32'h0000_0000;
        if (addr_hit(i_wb_adr, ADDR_MODE_LOW)) begin
            rdata[7:0] = cfg_q[7:0];
        end else if (addr_hit(i_wb_adr, ADDR_MODE_HIGH)) begin
            rdata[7:0] = cfg_q[15:8];
        end else if (addr_hit(i_wb_adr, ADDR_RUN_CTRL)) begin
            rdata[RUN_START_BIT] = online_q;
        end
    end

    always_ff @(posedge i_clock or negedge rst_n_q) begin
        if (!rst_n_q) begin
            rdata_q <= 32'h0000_0000;
        end else if (ack_d) begin
            rdata_q <= i_wb_we ? 32'h0000_0000 : rdata;
        end
    end

    // ****************************************************************
    // configuration register
    // ****************************************************************
    logic [15:0] cfg_d;
    logic        prm_take;

    assign prm_take = i_prm_valid && cfg_q.dp_protocol_enable;

    always_comb begin
        cfg_d = cfg_q;
        // locked while running, a write then only completes the cycle
        if (commit && !online_q && i_wb_sel[0]) begin
            if (addr_hit(i_wb_adr, ADDR_MODE_LOW)) begin
                cfg_d[7:0] = i_wb_dat[7:0];
            end else if (addr_hit(i_wb_adr, ADDR_MODE_HIGH)) begin
                cfg_d[15:8] = i_wb_dat[7:0];
            end
        end
        if (prm_take) begin
            cfg_d[1:0] = i_prm_check_off;
        end
        cfg_d = cfg_d & MODE_CONFIG_WMASK;
    end

    always_ff @(posedge i_clock or negedge rst_n_q) begin
        if (!rst_n_q) begin
            cfg_q <= mode_config_type'(MODE_CONFIG_RESET);
        end else begin
            cfg_q <= mode_config_type'(cfg_d);
        end
    end

    // ****************************************************************
    // offline and online
    // ****************************************************************
    logic start_wr;
    logic stop_wr;

    assign start_wr = commit && i_wb_sel[0] && addr_hit(i_wb_adr, ADDR_RUN_CTRL)
                      && i_wb_dat[RUN_START_BIT];
    assign stop_wr  = commit && i_wb_sel[0] && addr_hit(i_wb_adr, ADDR_RUN_CTRL)
                      && i_wb_dat[RUN_STOP_BIT];

    // going offline wins when both bits are written together
    always_ff @(posedge i_clock or negedge rst_n_q) begin
        if (!rst_n_q) begin
            online_q <= 1'b0;
        end else if (stop_wr) begin
            online_q <= 1'b0;
        end else if (start_wr) begin
            online_q <= 1'b1;
        end
    end

    always_ff @(posedge i_clock or negedge rst_n_q) begin
        if (!rst_n_q) begin
            o_dp_service_access_points <= 1'b0;
        end else begin
            o_dp_service_access_points <= online_q && cfg_q.dp_protocol_enable;
        end
    end

    // ****************************************************************
    // interrupt pin with gap after end of interrupt
    // ****************************************************************
    logic gap_busy;
    logic irq_active;

    period_timer #(
        .WIDTH (TIMER_WIDTH)
    ) u_gap_timer (
        .i_clock (i_clock),
        .i_rst_n (rst_n_q),
        .i_start (i_eoi),
        .i_load  (pick_count(cfg_q.irq_gap_timebase, IRQ_GAP_SHORT_CYCLES,
                             GAP_LONG_CYCLES)),
        .o_busy  (gap_busy),
        .o_last  ()
    );

    assign irq_active = i_irq_request && !gap_busy && !i_eoi;

    // reset value is the inactive level of the low-active default
    always_ff @(posedge i_clock or negedge rst_n_q) begin
        if (!rst_n_q) begin
            o_irq_pin <= 1'b1;
        end else begin
            o_irq_pin <= cfg_q.irq_polarity ? irq_active : !irq_active;
        end
    end

    // ****************************************************************
    // user tick
    // ****************************************************************
    logic tick_busy;
    logic tick_last;

    period_timer #(
        .WIDTH (TIMER_WIDTH)
    ) u_tick_timer (
        .i_clock (i_clock),
        .i_rst_n (rst_n_q),
        .i_start (online_q && (!tick_busy || tick_last)),
        .i_load  (pick_count(cfg_q.user_tick_timebase, TICK_SHORT_PERIOD,
                             TICK_LONG_PERIOD)),
        .o_busy  (tick_busy),
        .o_last  (tick_last)
    );

    always_ff @(posedge i_clock or negedge rst_n_q) begin
        if (!rst_n_q) begin
            o_user_tick <= 1'b0;
        end else begin
            o_user_tick <= tick_last && online_q;
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    // fields 0..3, 6, 7, 11..13 steer logic outside this bank
    assign o_config  = cfg_q;
    assign o_online  = online_q;
    assign o_wb_ack  = ack_q;
    assign o_wb_dat  = rdata_q;

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!rst_n_q);

    logic [TIMER_WIDTH-1:0] sv_tick_cnt_q;
    logic                   sv_tick_seen_q;

    always_ff @(posedge i_clock or negedge rst_n_q) begin
        if (!rst_n_q) begin
            sv_tick_cnt_q  <= '0;
            sv_tick_seen_q <= 1'b0;
        end else if (o_user_tick || !online_q) begin
            sv_tick_cnt_q  <= '0;
            sv_tick_seen_q <= online_q;
        end else begin
            sv_tick_cnt_q <= sv_tick_cnt_q + TIMER_WIDTH'(1);
        end
    end

    property p_locked_online;
        (online_q && commit && !prm_take) |=> $stable(cfg_q);
    endproperty
    a_locked_online: assert property (p_locked_online) else $error("config changed");

    property p_start_goes_online;
        (start_wr && !stop_wr)
            |=> online_q ##1 o_dp_service_access_points == cfg_q.dp_protocol_enable;
    endproperty
    a_start_goes_online: assert property (p_start_goes_online) else $error("no start");

    property p_prm_override;
        prm_take |=> (cfg_q[1:0] == $past(i_prm_check_off));
    endproperty
    a_prm_override: assert property (p_prm_override) else $error("override lost");

    property p_early_ack;
        ($rose(i_wb_stb) && cfg_q.early_ready) |=> o_wb_ack;
    endproperty
    a_early_ack: assert property (p_early_ack) else $error("early ready late");

    property p_normal_ack;
        ($rose(i_wb_stb) && !cfg_q.early_ready) |=> !o_wb_ack ##1 o_wb_ack ##1 !o_wb_ack;
    endproperty
    a_normal_ack: assert property (p_normal_ack) else $error("ready timing wrong");

    property p_unused_zero;
        (cfg_q.unused == 2'b00) && (o_wb_dat[31:8] == 24'h000000);
    endproperty
    a_unused_zero: assert property (p_unused_zero) else $error("unused bits set");

    property p_gap_quiet;
        i_eoi |=> ##1 (o_irq_pin != cfg_q.irq_polarity) [*8];
    endproperty
    a_gap_quiet: assert property (p_gap_quiet) else $error("quiet gap broken");

    property p_polarity;
        (i_irq_request && !gap_busy && !i_eoi) |=> (o_irq_pin == $past(cfg_q.irq_polarity));
    endproperty
    a_polarity: assert property (p_polarity) else $error("interrupt level wrong");

    property p_tick_period;
        (o_user_tick && sv_tick_seen_q && $stable(cfg_q.user_tick_timebase))
            |-> (sv_tick_cnt_q == TIMER_WIDTH'(pick_count(cfg_q.user_tick_timebase,
                 TICK_SHORT_PERIOD, TICK_LONG_PERIOD) - TIMER_WIDTH'(1)));
    endproperty
    a_tick_period: assert property (p_tick_period) else $error("tick period wrong");

    property p_saps;
        ##1 (o_dp_service_access_points == $past(online_q && cfg_q.dp_protocol_enable));
    endproperty
    a_saps: assert property (p_saps) else $error("service points wrong");

    c_config_write: cover property (commit && !online_q && addr_hit(i_wb_adr, ADDR_MODE_HIGH));
    c_prm_override: cover property (prm_take && online_q);
    c_user_tick:    cover property (o_user_tick);
    c_eoi_gap:      cover property (i_eoi ##1 gap_busy && i_irq_request);

endmodule
`default_nettype wire

// *** testbench/host_bus_model.sv ***
// host processor model: classic wishbone master in front of the configuration bank
`timescale 1ns/1ps
`default_nettype none
module host_bus_model
    import mode_config_pkg::*;
(
    input  wire logic                  i_clock,
    input  wire logic                  i_break_rules,
    input  wire logic                  i_wb_ack,
    input  wire logic [31:0]           i_wb_dat,
    output logic                       o_wb_cyc,
    output logic                       o_wb_stb,
    output logic                       o_wb_we,
    output logic [ADDR_WIDTH-1:0]      o_wb_adr,
    output logic [3:0]                 o_wb_sel,
    output logic [31:0]                o_wb_dat
);
    logic       online_q = 1'b0;
    logic [1:0] loaded_q = 2'b00;

    initial begin
        o_wb_cyc = 1'b0;
        o_wb_stb = 1'b0;
        o_wb_we  = 1'b0;
        o_wb_adr = 8'h00;
        o_wb_sel = 4'h0;
        o_wb_dat = 32'h0;
    end

    // ****************************************************************
    // one classic cycle; waited counts edges up to ack, 0 when a polite host skips it
    // ****************************************************************
    task automatic access(input logic we, input logic [7:0] adr, input logic [7:0] wdat,
                          input logic [3:0] sel, output logic [31:0] rdat, output int waited);
        logic [7:0] d;
        d = wdat;
        waited = -1;
        rdat = 32'h0;
        if (adr == ADDR_MODE_LOW) d[2] = 1'b0;
        if (adr == ADDR_MODE_HIGH) d[3] = 1'b0;
        // a polite host skips these; the bench only asks for them on purpose
        if (!i_break_rules && we && ((online_q && adr inside {ADDR_MODE_LOW, ADDR_MODE_HIGH})
            || (adr == ADDR_RUN_CTRL && d[0] && loaded_q != 2'b11))) begin
            waited = 0;
            return;
        end
        @(posedge i_clock);
        o_wb_cyc <= 1'b1;
        o_wb_stb <= 1'b1;
        o_wb_we  <= we;
        o_wb_adr <= adr;
        o_wb_sel <= sel;
        o_wb_dat <= {24'h0, d};
        // no cycle count is assumed: only the bench watchdog ends a hung wait
        waited = 0;
        do begin
            @(posedge i_clock);
            waited++;
        end while (i_wb_ack !== 1'b1);
        rdat = i_wb_dat;
        if (we && sel[0] && adr == ADDR_MODE_LOW) loaded_q[0] = 1'b1;
        if (we && sel[0] && adr == ADDR_MODE_HIGH) loaded_q[1] = 1'b1;
        if (we && sel[0] && adr == ADDR_RUN_CTRL) online_q = d[1] ? 1'b0 : (d[0] | online_q);
        // released lines show no stale value
        o_wb_cyc <= 1'b0;
        o_wb_stb <= 1'b0;
        o_wb_adr <= ~adr;
        o_wb_dat <= ~{24'h0, d};
        @(posedge i_clock);
    endtask
endmodule
`default_nettype wire

// *** testbench/test_fieldbus_mode_config.sv ***
// self-checking bench for the fieldbus mode configuration register bank
`timescale 1ns/1ps
`default_nettype none
module test_fieldbus_mode_config
    import mode_config_pkg::*;
;
    localparam int GAP_LONG   = 20;
    localparam int TICK_SHORT = 16;
    localparam int TICK_LONG  = 40;
    logic            i_clock;
    logic            i_rstn;
    logic            prm_valid;
    logic [1:0]      prm_check_off;
    logic            irq_request;
    logic            eoi;
    logic            break_rules;
    logic            wb_cyc;
    logic            wb_stb;
    logic            wb_we;
    logic            wb_ack;
    logic [7:0]      wb_adr;
    logic [3:0]      wb_sel;
    logic [31:0]     wb_wdat;
    logic [31:0]     wb_rdat;
    mode_config_type config_out;
    logic            online;
    logic            saps;
    logic            irq_pin;
    logic            user_tick;
    int              num_errors;
    int              checked;
    int              seed;
    int              lat;
    int              lat0;
    int              n;
    int              g;
    logic [15:0]     v;
    logic [15:0]     e;
    logic [31:0]     r;

    fieldbus_mode_config #(.GAP_LONG_CYCLES(GAP_LONG), .TICK_SHORT_PERIOD(TICK_SHORT),
        .TICK_LONG_PERIOD(TICK_LONG)) u_fieldbus_mode_config (
        .i_clock(i_clock), .i_rstn(i_rstn), .i_wb_cyc(wb_cyc), .i_wb_stb(wb_stb),
        .i_wb_we(wb_we), .i_wb_adr(wb_adr), .i_wb_sel(wb_sel), .i_wb_dat(wb_wdat),
        .o_wb_ack(wb_ack), .o_wb_dat(wb_rdat), .i_prm_valid(prm_valid),
        .i_prm_check_off(prm_check_off), .i_irq_request(irq_request), .i_eoi(eoi),
        .o_config(config_out), .o_online(online), .o_dp_service_access_points(saps),
        .o_irq_pin(irq_pin), .o_user_tick(user_tick));

    host_bus_model u_host_bus_model (
        .i_clock(i_clock), .i_break_rules(break_rules), .i_wb_ack(wb_ack), .i_wb_dat(wb_rdat),
        .o_wb_cyc(wb_cyc), .o_wb_stb(wb_stb), .o_wb_we(wb_we), .o_wb_adr(wb_adr),
        .o_wb_sel(wb_sel), .o_wb_dat(wb_wdat));

    // ****************************************************************
    // helpers
    // ****************************************************************
    function automatic logic [15:0] exp_cfg(input logic [15:0] x);
        return x & MODE_CONFIG_WMASK;
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic bus(input logic we, input logic [7:0] adr, input logic [7:0] d,
                       input logic [3:0] sel);
        u_host_bus_model.access(we, adr, d, sel, r, lat);
        chk(32'(lat > 0), 32'h1);
    endtask

    task automatic set_cfg(input logic [15:0] x);
        bus(1'b1, ADDR_MODE_LOW, x[7:0], 4'h1);
        bus(1'b1, ADDR_MODE_HIGH, x[15:8], 4'h1);
    endtask

    // one period between ticks; a silent line gives the bound of 500
    task automatic tick_gap(output int t);
        t = 0;
        do begin
            @(posedge i_clock);
            t++;
        end while (user_tick !== 1'b1 && t < 500);
    endtask

    task automatic give_verdict();
        $display("comparisons %0d, errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    initial begin
        i_clock = 1'b0;
        forever #5 i_clock = ~i_clock;
    end

    initial begin
        #400000;
        num_errors++;
        give_verdict();
    end

    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        seed = 32'hefca;
        num_errors = 0;
        checked = 0;
        i_rstn = 1'b0;
        prm_valid = 1'b0;
        prm_check_off = 2'b00;
        irq_request = 1'b0;
        eoi = 1'b0;
        break_rules = 1'b0;
        repeat (2) @(posedge i_clock);
        i_rstn <= 1'b1;
        repeat (4) @(posedge i_clock);
        chk(32'(config_out), 32'h0);
        chk(32'({online, saps, irq_pin, user_tick}), 32'h2);
        // field walk: all allowed ones first, then random patterns
        for (int k = 0; k < 12; k++) begin
            v = (k == 0) ? 16'hf7fb : 16'($random(seed)) & 16'hf7fb;
            e = exp_cfg(v);
            set_cfg(v);
            chk(32'(config_out), {16'h0, e});
            chk(32'(config_out[13:12]), 32'(e[13:12]));
            chk(32'(config_out[7:6]), 32'(e[7:6]));
            chk(32'(config_out[1:0]), 32'(e[1:0]));
            bus(1'b0, ADDR_MODE_LOW, 8'h00, 4'h1);
            chk(r, {24'h0, e[7:0]});
            bus(1'b0, ADDR_MODE_HIGH, 8'h00, 4'h1);
            chk(r, {24'h0, e[15:8]});
        end
        bus(1'b1, ADDR_MODE_LOW, ~e[7:0], 4'h0);
        bus(1'b1, 8'h20, 8'hff, 4'h1);
        bus(1'b0, 8'h20, 8'h00, 4'h1);
        chk(r, 32'h0);
        chk(32'(config_out), {16'h0, e});
        // ready one clock earlier with bit 5
        set_cfg(16'h0000);
        bus(1'b0, ADDR_MODE_LOW, 8'h00, 4'h1);
        lat0 = lat;
        set_cfg(16'h0020);
        bus(1'b0, ADDR_MODE_LOW, 8'h00, 4'h1);
        chk(32'(lat0 - lat), 32'h1);
        // parameter telegram check bits, with and without dp_protocol_enable
        for (int k = 0; k < 5; k++) begin
            if (k == 0) set_cfg(16'h0100);
            if (k == 4) set_cfg(16'h0000);
            prm_valid <= 1'b1;
            prm_check_off <= (k == 4) ? 2'b11 : 2'(k);
            @(posedge i_clock);
            prm_valid <= 1'b0;
            @(posedge i_clock);
            chk({config_out.stop_bit_check_off, config_out.start_bit_check_off}, k % 4);
        end
        // interrupt polarity and quiet gap after end of interrupt
        for (int k = 0; k < 4; k++) begin
            set_cfg({6'h0, k[1], 4'h0, k[0], 4'h0});
            g = k[1] ? GAP_LONG : IRQ_GAP_SHORT_CYCLES;
            irq_request <= 1'b0;
            repeat (3) @(posedge i_clock);
            chk(irq_pin, !k[0]);
            irq_request <= 1'b1;
            repeat (3) @(posedge i_clock);
            chk(irq_pin, k[0]);
            eoi <= 1'b1;
            @(posedge i_clock);
            eoi <= 1'b0;
            repeat (g - 2) @(posedge i_clock);
            chk(irq_pin, !k[0]);
            repeat (6) @(posedge i_clock);
            chk(irq_pin, k[0]);
        end
        irq_request <= 1'b0;
        // online with dp_protocol_enable, both tick periods, refused writes, offline again
        for (int k = 0; k < 2; k++) begin
            v = {5'h0, k[0], 10'h100};
            set_cfg(v);
            bus(1'b1, ADDR_RUN_CTRL, 8'h01, 4'h1);
            repeat (2) @(posedge i_clock);
            chk(32'({online, saps}), 32'h3);
            bus(1'b0, ADDR_RUN_CTRL, 8'h00, 4'h1);
            chk(r, 32'h1);
            tick_gap(n);
            tick_gap(n);
            chk(n, k[0] ? TICK_LONG : TICK_SHORT);
            break_rules <= 1'b1;
            @(posedge i_clock);
            bus(1'b1, ADDR_MODE_LOW, 8'hff, 4'h1);
            break_rules <= 1'b0;
            chk(32'(config_out), {16'h0, v});
            bus(1'b1, ADDR_RUN_CTRL, 8'h03, 4'h1);
            repeat (2) @(posedge i_clock);
            chk(32'({online, saps}), 32'h0);
            tick_gap(n);
            chk(n, 500);
        end
        give_verdict();
    end
endmodule
`default_nettype wire
